// >>> hdl/cpia_assembly.sv
// cyclic input assembly producer with avalon-mm control registers
// ****************************************************************
// ****************************************************************
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cpia_map.svh"

module cpia_assembly #(
  parameter logic [31:0] RPI_DEFAULT = `CPIA_RPI_DEF_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  // reader sources
  input wire logic [31:0] position_i,
  input wire logic [7:0] velocity_i,
  input wire logic partial_off_track_i,
  input wire logic full_off_track_i,
  input wire logic dirt_warning_i,
  input wire logic speed_unknown_i,
  input wire logic fault_no_position_a_i,
  input wire logic fault_no_position_b_i,
  input wire logic fault_working_memory_i,
  input wire logic fault_prog_memory_decoder_i,
  input wire logic fault_readonly_memory_i,
  // connection open and close from the originator
  input wire logic conn_req_i,
  input wire logic [7:0] conn_out_inst_i,
  input wire logic [15:0] conn_out_size_i,
  input wire logic [7:0] conn_in_inst_i,
  input wire logic conn_close_i,
  output logic conn_ack_o,
  output logic conn_nak_o,
  // attribute services from the network
  input wire logic attr_req_i,
  output logic attr_nak_o,
  // produced assembly bytes
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    cpia_pkg::cpia_fsm_t fsm;
    logic enable;
    logic [31:0] rpi;
    logic [31:0] rpi_cnt;
    logic conn_open;
    logic conn_full;
    logic conn_listen;
    logic [55:0] frame;
    logic [2:0] left;
    logic [31:0] last_pos;
    logic [23:0] last_info;
    logic [`CPIA_IRQ_W-1:0] irq_stat;
    logic [`CPIA_IRQ_W-1:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
    logic conn_ack;
    logic conn_nak;
    logic attr_nak;
  } cpia_state_t;

  cpia_state_t st;
  cpia_state_t next_st;

  logic req;
  logic wr_go;
  logic [31:0] wmask;
  logic [7:0] status_b;
  logic [7:0] fault_b;
  logic [7:0] vel_b;
  logic pos_bad;
  logic tick;
  logic conn_good;
  logic [`CPIA_IRQ_W-1:0] ev;

  // a request is answered after exactly one wait cycle
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~st.ack;
  assign wr_go = avs_write_i & st.ack;
  assign avs_readdata_o = st.rdata;
  assign irq_o = |(st.irq_stat & st.irq_mask);

  // byte lane mask from byte enables
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable_i[i]}};
    end
  end

  // ****************************************************************
  // sample-side field building
  // ****************************************************************
  // position outside the rail or beyond travel cannot be trusted
  assign pos_bad = partial_off_track_i | full_off_track_i
    | ($signed(position_i) < 0)
    | ($signed(position_i) > $signed(`CPIA_POS_MAX_COUNT));

  // fault byte: undefined bits 0, 6 and 7 stay zero
  always_comb begin
    fault_b = 8'h00;
    fault_b[`CPIA_FLT_NOPOS_A] = fault_no_position_a_i | pos_bad;
    fault_b[`CPIA_FLT_NOPOS_B] = fault_no_position_b_i;
    fault_b[`CPIA_FLT_WORK_MEM] = fault_working_memory_i;
    fault_b[`CPIA_FLT_PROG_MEM] = fault_prog_memory_decoder_i;
    fault_b[`CPIA_FLT_RO_MEM] = fault_readonly_memory_i;
  end

  // status byte: error derived from the same fault byte sent
  always_comb begin
    status_b = 8'h00;
    status_b[`CPIA_ST_ERROR] = |fault_b;
    status_b[`CPIA_ST_PART_OFF] = partial_off_track_i;
    status_b[`CPIA_ST_FULL_OFF] = full_off_track_i;
    status_b[`CPIA_ST_DIRT] = dirt_warning_i;
    status_b[`CPIA_ST_SPEED_UNK] = speed_unknown_i;
  end

  // velocity passes as plain unsigned dm/s; zero when unknown
  assign vel_b = speed_unknown_i ? 8'h00 : velocity_i;

  // production interval expiry
  assign tick = st.conn_open & st.enable & (st.rpi_cnt == 32'h0000_0000);

  // only zero-size output points and known input instances open
  assign conn_good = st.enable
    & ((conn_out_inst_i == `CPIA_INST_LISTEN)
       | (conn_out_inst_i == `CPIA_INST_INONLY))
    & (conn_out_size_i == `CPIA_OUT_SIZE)
    & ((conn_in_inst_i == `CPIA_INST_POS)
       | (conn_in_inst_i == `CPIA_INST_FULL));

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign tx_valid_o = (st.fsm == cpia_pkg::CPIA_SEND);
  assign tx_data_o = st.frame[7:0];
  assign tx_last_o = tx_valid_o & (st.left == 3'h1);
  assign conn_ack_o = st.conn_ack;
  assign conn_nak_o = st.conn_nak;
  assign attr_nak_o = st.attr_nak;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    ev = '0;
    next_st.conn_ack = 1'b0;
    next_st.conn_nak = 1'b0;
    next_st.attr_nak = 1'b0;
    next_st.ack = req & ~st.ack;

    // attribute services never reach the parameters
    if (attr_req_i) begin
      next_st.attr_nak = 1'b1;
      ev[`CPIA_IRQ_ATTR_NAK] = 1'b1;
    end

    // connection handling; the assembly layout is not negotiable
    if (conn_close_i) begin
      next_st.conn_open = 1'b0;
    end else if (conn_req_i) begin
      if (conn_good) begin
        next_st.conn_ack = 1'b1;
        next_st.conn_open = 1'b1;
        next_st.conn_full = (conn_in_inst_i == `CPIA_INST_FULL);
        next_st.conn_listen = (conn_out_inst_i == `CPIA_INST_LISTEN);
        next_st.rpi_cnt = 32'h0000_0000;
        ev[`CPIA_IRQ_CONN_OK] = 1'b1;
      end else begin
        next_st.conn_nak = 1'b1;
        ev[`CPIA_IRQ_CONN_NAK] = 1'b1;
      end
    end

    // interval counter reloads on expiry
    if (st.conn_open & st.enable & ~conn_req_i) begin
      if (tick) begin
        next_st.rpi_cnt = st.rpi - 32'h0000_0001;
      end else begin
        next_st.rpi_cnt = st.rpi_cnt - 32'h0000_0001;
      end
    end

    // producer
    case (st.fsm)
      cpia_pkg::CPIA_IDLE: begin
        if (tick) begin
          // every field captured in this one cycle
          next_st.frame = {fault_b, vel_b, status_b,
            position_i};
          next_st.left = st.conn_full ? `CPIA_LEN_FULL
            : `CPIA_LEN_POS;
          next_st.last_pos = position_i;
          next_st.last_info = {fault_b, vel_b, status_b};
          next_st.fsm = cpia_pkg::CPIA_SEND;
          ev[`CPIA_IRQ_FAULT] = |fault_b;
        end
      end
      cpia_pkg::CPIA_SEND: begin
        if (tick) begin
          // previous frame still draining: skip this interval
          ev[`CPIA_IRQ_OVERRUN] = 1'b1;
        end
        if (tx_ready_i) begin
          next_st.frame = {8'h00, st.frame[55:8]};
          next_st.left = st.left - 3'h1;
          if (st.left == 3'h1) begin
            next_st.fsm = cpia_pkg::CPIA_IDLE;
            ev[`CPIA_IRQ_FRAME] = 1'b1;
          end
        end
      end
      default: begin
        next_st.fsm = cpia_pkg::CPIA_IDLE;
      end
    endcase

    // register writes
    if (wr_go) begin
      case (avs_address_i)
        `CPIA_REG_CTRL: begin
          if (avs_byteenable_i[0]) begin
            next_st.enable = avs_writedata_i[0];
            if (!avs_writedata_i[0]) begin
              next_st.conn_open = 1'b0;
            end
          end
        end
        `CPIA_REG_RPI: begin
          next_st.rpi = (st.rpi & ~wmask) | (avs_writedata_i & wmask);
        end
        `CPIA_REG_IRQ_STAT: begin
          if (avs_byteenable_i[0]) begin
            next_st.irq_stat = st.irq_stat
              & ~avs_writedata_i[`CPIA_IRQ_W-1:0];
          end
        end
        `CPIA_REG_IRQ_MASK: begin
          if (avs_byteenable_i[0]) begin
            next_st.irq_mask = avs_writedata_i[`CPIA_IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // a new event wins over a clear in the same cycle
    next_st.irq_stat = next_st.irq_stat | ev;

    // register reads, captured during the wait cycle
    if (avs_read_i & ~st.ack) begin
      case (avs_address_i)
        `CPIA_REG_CTRL: next_st.rdata = {31'h0000_0000, st.enable};
        `CPIA_REG_RPI: next_st.rdata = st.rpi;
        `CPIA_REG_STATE: begin
          next_st.rdata = {27'h000_0000, st.conn_listen, st.conn_full,
            st.conn_open, st.fsm};
        end
        `CPIA_REG_IRQ_STAT: begin
          next_st.rdata = {26'h000_0000, st.irq_stat};
        end
        `CPIA_REG_IRQ_MASK: begin
          next_st.rdata = {26'h000_0000, st.irq_mask};
        end
        `CPIA_REG_LAST_POS: next_st.rdata = st.last_pos;
        `CPIA_REG_LAST_INFO: next_st.rdata = {8'h00, st.last_info};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.fsm <= cpia_pkg::CPIA_IDLE;
      st.rpi <= RPI_DEFAULT;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/cpia_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef CPIA_MAP_SVH
`define CPIA_MAP_SVH

// ****************************************************************
// connection points and assembly instances
// ****************************************************************
`define CPIA_INST_POS 8'h01
`define CPIA_INST_FULL 8'h64
`define CPIA_INST_LISTEN 8'hC0
`define CPIA_INST_INONLY 8'hC1
`define CPIA_OUT_SIZE 16'h0000
`define CPIA_LEN_POS 3'h4
`define CPIA_LEN_FULL 3'h7

// ****************************************************************
// field positions of status and fault bytes
// ****************************************************************
`define CPIA_ST_ERROR 0
`define CPIA_ST_PART_OFF 1
`define CPIA_ST_FULL_OFF 2
`define CPIA_ST_DIRT 3
`define CPIA_ST_SPEED_UNK 4
`define CPIA_FLT_NOPOS_A 1
`define CPIA_FLT_NOPOS_B 2
`define CPIA_FLT_WORK_MEM 3
`define CPIA_FLT_PROG_MEM 4
`define CPIA_FLT_RO_MEM 5

// ****************************************************************
// position scale: 0.8 mm per count, travel 314500 mm
// ****************************************************************
`define CPIA_UM_PER_COUNT 800
`define CPIA_TRAVEL_MM 314500
`define CPIA_POS_MAX_COUNT \
  ((`CPIA_TRAVEL_MM * 1000) / `CPIA_UM_PER_COUNT)

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CPIA_REG_CTRL 5'h00
`define CPIA_REG_RPI 5'h04
`define CPIA_REG_STATE 5'h08
`define CPIA_REG_IRQ_STAT 5'h0C
`define CPIA_REG_IRQ_MASK 5'h10
`define CPIA_REG_LAST_POS 5'h14
`define CPIA_REG_LAST_INFO 5'h18

// ****************************************************************
// interrupt bits and reset values
// ****************************************************************
`define CPIA_IRQ_FRAME 0
`define CPIA_IRQ_CONN_OK 1
`define CPIA_IRQ_CONN_NAK 2
`define CPIA_IRQ_ATTR_NAK 3
`define CPIA_IRQ_FAULT 4
`define CPIA_IRQ_OVERRUN 5
`define CPIA_IRQ_W 6
`define CPIA_CLK_MHZ 20
`define CPIA_RPI_DEF_US 1000
`define CPIA_RPI_DEF_CYC (`CPIA_RPI_DEF_US * `CPIA_CLK_MHZ)

`endif

// >>> hdl/cpia_pkg.sv
// types shared by the position input assembly block
package cpia_pkg;

  // producer state, one-hot
  typedef enum logic [1:0] {
    CPIA_IDLE = 2'b01,
    CPIA_SEND = 2'b10
  } cpia_fsm_t;

endpackage

// >>> verif/cpia_assertions.sv
// checker of produced assembly bytes and of refused requests
`timescale 1ns/100ps
`default_nettype none
module cpia_assertions (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic conn_req_i,
  input wire logic [15:0] conn_out_size_i,
  input wire logic [7:0] conn_in_inst_i,
  input wire logic conn_close_i,
  input wire logic conn_nak_o,
  input wire logic attr_req_i,
  input wire logic attr_nak_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i
);
  logic [2:0] idx;
  logic [7:0] st;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // byte count in the frame; status kept to judge the later bytes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      idx <= 3'h0;
      st <= 8'h00;
    end else if (tx_valid_o && tx_ready_i) begin
      idx <= tx_last_o ? 3'h0 : idx + 3'h1;
      st <= (idx == 3'h4) ? tx_data_o : st;
    end
  end
  property p_attr;
    attr_req_i |=> attr_nak_o;
  endproperty
  a_attr: assert property (p_attr) else $error("attr not refused");
  property p_size;
    conn_req_i && !conn_close_i && conn_out_size_i != 16'h0000 |=> conn_nak_o;
  endproperty
  a_size: assert property (p_size) else $error("size not refused");
  property p_inst;
    conn_req_i && !conn_close_i && conn_in_inst_i != 8'h01 &&
      conn_in_inst_i != 8'h64 |=> conn_nak_o;
  endproperty
  a_inst: assert property (p_inst) else $error("inst not refused");
  property p_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("byte changed");
  property p_last;
    tx_valid_o && tx_last_o |-> idx == 3'h3 || idx == 3'h6;
  endproperty
  a_last: assert property (p_last) else $error("bad length");
  property p_res;
    tx_valid_o && idx == 3'h4 |-> tx_data_o[7:5] == 3'h0;
  endproperty
  a_res: assert property (p_res) else $error("status spare set");
  property p_flt;
    tx_valid_o && idx == 3'h6 |-> st[0] == (tx_data_o != 8'h00) &&
      tx_data_o[0] == 1'b0 && tx_data_o[7:6] == 2'h0;
  endproperty
  a_flt: assert property (p_flt) else $error("bad fault");
  property p_spd;
    tx_valid_o && idx == 3'h5 && st[4] |-> tx_data_o == 8'h00;
  endproperty
  a_spd: assert property (p_spd) else $error("speed not zero");
  c_nak: cover property (attr_nak_o);
  c_stall: cover property (tx_valid_o && !tx_ready_i);
  c_full: cover property (tx_valid_o && tx_ready_i && idx == 3'h6);
endmodule
bind cpia_assembly cpia_assertions u_chk (.clk_sys_i, .rst_i, .conn_req_i,
  .conn_out_size_i, .conn_in_inst_i, .conn_close_i, .conn_nak_o,
  .attr_req_i, .attr_nak_o, .tx_valid_o, .tx_data_o, .tx_last_o,
  .tx_ready_i);
`default_nettype wire

// >>> verif/cpia_originator.sv
// originator model: takes produced assembly bytes, may stall
`timescale 1ns/100ps
`default_nettype none
module cpia_originator (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  output logic [55:0] frame_o,
  output logic [2:0] len_o,
  output logic [15:0] frames_o
);
  logic [2:0] n;
  // a slow originator accepts only every other cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
      n <= 3'h0;
      len_o <= 3'h0;
      frames_o <= 16'h0000;
      frame_o <= '0;
    end else begin
      tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
      if (tx_valid_i && tx_ready_o) begin
        frame_o[n*8 +: 8] <= tx_data_i; // first byte lands lowest
        n <= tx_last_i ? 3'h0 : n + 3'h1;
        if (tx_last_i) begin
          len_o <= n + 3'h1;
          frames_o <= frames_o + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/test_cip_position_input_assembly.sv
// self-checking bench for the position input assembly producer
`timescale 1ns/100ps
`default_nettype none
module test_cip_position_input_assembly;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o, rdata;
  logic avs_waitrequest_o, irq_o, conn_ack_o, conn_nak_o, attr_nak_o;
  logic [31:0] position_i = 32'h0000_0000;
  logic [7:0] velocity_i = 8'h00;
  logic [8:0] flg = 9'h000;
  logic conn_req_i = 1'b0;
  logic attr_req_i = 1'b0;
  logic slow = 1'b0;
  logic [7:0] conn_out_inst_i = 8'h00;
  logic [7:0] conn_in_inst_i = 8'h00;
  logic [15:0] conn_out_size_i = 16'h0000;
  logic tx_valid_o, tx_last_o, tx_ready_i;
  logic [7:0] tx_data_o;
  logic [55:0] frame;
  logic [2:0] len;
  logic [15:0] nfr;
  int fails = 0;
  int comparisons = 0;
  logic [31:0] pos_t [5] = '{32'h0001_2345, 32'h0005_FFA5, 32'h0005_FFA6,
                             32'hFFFF_FFFB, 32'h7FFF_0000};
  logic [7:0] vel_t [5] = '{8'h2A, 8'hFF, 8'h01, 8'h10, 8'h80};
  logic [8:0] flg_t [5] = '{9'h000, 9'h060, 9'h100, 9'h095, 9'h00A};
  always #25 clk_sys_i = ~clk_sys_i;
  // flags: partial, full, dirt, speed, no pos a/b, work, prog, rom
  cpia_assembly #(.RPI_DEFAULT(32'h0000_0028)) dut (.clk_sys_i, .rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .irq_o,
    .position_i, .velocity_i, .partial_off_track_i(flg[8]),
    .full_off_track_i(flg[7]), .dirt_warning_i(flg[6]),
    .speed_unknown_i(flg[5]), .fault_no_position_a_i(flg[4]),
    .fault_no_position_b_i(flg[3]), .fault_working_memory_i(flg[2]),
    .fault_prog_memory_decoder_i(flg[1]), .fault_readonly_memory_i(flg[0]),
    .conn_req_i, .conn_out_inst_i, .conn_out_size_i, .conn_in_inst_i,
    .conn_close_i(1'b0), .conn_ack_o, .conn_nak_o, .attr_req_i, .attr_nak_o,
    .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i);
  cpia_originator orig (.clk_sys_i, .rst_i, .slow_i(slow),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o),
    .tx_ready_o(tx_ready_i), .frame_o(frame), .len_o(len), .frames_o(nfr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= d;
    // look at waitrequest where it is settled, then complete on the edge
    do begin
      @(negedge clk_sys_i);
      t++;
    end while (avs_waitrequest_o !== 1'b0 && t < 100);
    if (t >= 100) begin
      fails++;
    end
    @(posedge clk_sys_i);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic open_conn(input logic [7:0] oi, input logic [15:0] sz,
                           input logic [7:0] ii, input logic [1:0] exp);
    @(posedge clk_sys_i);
    conn_req_i <= 1'b1;
    conn_out_inst_i <= oi;
    conn_out_size_i <= sz;
    conn_in_inst_i <= ii;
    @(posedge clk_sys_i);
    conn_req_i <= 1'b0;
    // the answer stands for one cycle only; look in its middle
    @(negedge clk_sys_i);
    chk({30'h0, conn_ack_o, conn_nak_o}, {30'h0, exp});
  endtask
  task automatic wait_frames(input logic [15:0] k);
    logic [15:0] s;
    s = nfr;
    for (int i = 0; i < 4000 && nfr < s + k; i++) @(posedge clk_sys_i);
  endtask
  // second frame is surely sampled after the sources last changed
  task automatic frame_chk(input logic [2:0] n);
    logic [7:0] f;
    logic [7:0] s;
    wait_frames(16'h0002);
    f = {2'h0, flg[0], flg[1], flg[2], flg[3], 1'b0, 1'b0};
    f[1] = flg[8] | flg[7] | flg[4] | (position_i > 32'h0005_FFA5);
    s = {3'h0, flg[5], flg[6], flg[7], flg[8], |f};
    chk({29'h0, len}, {29'h0, n});
    chk(frame[31:0], position_i);
    if (n == 3'h7) begin
      chk({8'h00, frame[55:32]},
          {8'h00, f, (flg[5] ? 8'h00 : velocity_i), s});
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #500_000;
    fails++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    bus(1'b0, 5'h04, 32'h0000_0000);
    chk(rdata, 32'h0000_0028);
    bus(1'b0, 5'h1C, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    bus(1'b1, 5'h04, 32'h0000_0020);
    $display("test registers done");
    open_conn(8'hC0, 16'h0000, 8'h64, 2'h1);
    bus(1'b1, 5'h00, 32'h0000_0001);
    open_conn(8'hC0, 16'h0001, 8'h64, 2'h1);
    open_conn(8'hC2, 16'h0000, 8'h64, 2'h1);
    open_conn(8'hC1, 16'h0000, 8'h02, 2'h1);
    open_conn(8'hC0, 16'h0000, 8'h64, 2'h2);
    $display("test connections done");
    for (int i = 0; i < 5; i++) begin
      slow <= i[0];
      position_i <= pos_t[i];
      velocity_i <= vel_t[i];
      flg <= flg_t[i];
      frame_chk(3'h7);
    end
    // move the position while a frame is going out at full rate
    for (int i = 0; i < 400 && tx_valid_o !== 1'b1; i++) @(posedge clk_sys_i);
    rdata = position_i;
    position_i <= ~position_i;
    wait_frames(16'h0001);
    chk(frame[31:0], rdata);
    open_conn(8'hC1, 16'h0000, 8'h01, 2'h2);
    frame_chk(3'h4);
    $display("test frames done");
    bus(1'b1, 5'h10, 32'h0000_0008);
    bus(1'b1, 5'h0C, 32'h0000_003F);
    chk({31'h0, irq_o}, 32'h0000_0000);
    @(posedge clk_sys_i);
    attr_req_i <= 1'b1;
    @(posedge clk_sys_i);
    attr_req_i <= 1'b0;
    @(negedge clk_sys_i);
    chk({31'h0, attr_nak_o}, 32'h0000_0001);
    bus(1'b0, 5'h0C, 32'h0000_0000);
    chk(rdata & 32'h0000_0008, 32'h0000_0008);
    chk({31'h0, irq_o}, 32'h0000_0001);
    bus(1'b1, 5'h0C, 32'h0000_0008);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    $display("test refusal and interrupt done");
    final_report();
  end
endmodule
`default_nettype wire
